// ---- rtl/meb_pkg.sv ----
package meb_pkg;

  // Build-time defaults
  localparam int DEF_DATA_W      = 32;
  localparam int DEF_ADDR_W      = 32;
  localparam int MAX_ADDR_W      = 32;
  localparam int BYTE_W          = 8;

  // Decoded range is a count times a unit
  localparam longint unsigned UNIT_BYTES  = 64'h1;
  localparam longint unsigned UNIT_KBYTES = 64'h400;
  localparam longint unsigned UNIT_MBYTES = 64'h10_0000;
  localparam longint unsigned DEF_RANGE_COUNT = 64'h400;

  // No length is given for the time-out; plain default in clock cycles
  localparam int DEF_TIMEOUT_CYCLES = 256;

  // Direction encoding on the external bus
  localparam logic DIR_READ  = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WAIT,
    ST_CAPTURE,
    ST_DONE
  } meb_state_type;

endpackage : meb_pkg

// ---- rtl/meb_bridge.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - External address is at most 32 bits and aligned to the data size.
// - Data paths share one width of 8 to 128 bits; lanes are width/8.
// - Each active-high lane bit marks a data byte taking part in the transfer.
// - While transfer valid is high, all other outgoing bus signals are valid.
// - Direction is 1 for read, 0 for write.
// - Address, direction, lanes and data settle one cycle before transfer valid rises.
// - Peripheral interrupt line is passed back upstream.
// - A time-out ends a stalled transfer so the fabric never hangs.
// - Registering adds one cycle to writes and two cycles to reads.
// - Decoded range is 1 to 1024 units of bytes, kilobytes or megabytes.
module meb_bridge #(
  parameter int              DATA_W         = meb_pkg::DEF_DATA_W,
  parameter int              ADDR_W         = meb_pkg::DEF_ADDR_W,
  parameter longint unsigned RANGE_COUNT    = meb_pkg::DEF_RANGE_COUNT,
  parameter longint unsigned RANGE_UNIT     = meb_pkg::UNIT_BYTES,
  parameter int              TIMEOUT_CYCLES = meb_pkg::DEF_TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Upstream fabric slave
  input  wire logic                  upSelect,
  input  wire logic                  upRead,
  input  wire logic                  upWrite,
  input  wire logic [ADDR_W-1:0]     upAddress,
  input  wire logic [DATA_W/8-1:0]   upLanes,
  input  wire logic [DATA_W-1:0]     upWrData,
  output logic      [DATA_W-1:0]     upRdData,
  output logic                       upWaitRequest,
  output logic                       upTimedOut,
  output logic                       upIrq,
  // External peripheral bus
  output logic      [ADDR_W-1:0]     extAddress,
  output logic      [DATA_W-1:0]     wrPayload,
  output logic      [DATA_W/8-1:0]   laneSelect,
  output logic                       isRead,
  output logic                       transferValid,
  input  wire logic [DATA_W-1:0]     rdPayload,
  input  wire logic                  doneStrobe,
  input  wire logic                  periphIrq
);

  localparam int              LANES    = DATA_W / meb_pkg::BYTE_W;
  localparam int              LOW_BITS = (LANES > 1) ? $clog2(LANES) : 1;
  localparam longint unsigned LIMIT    = RANGE_COUNT * RANGE_UNIT;
  localparam int              CNT_W    = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYCLES - 1);

  initial begin
    if (ADDR_W > meb_pkg::MAX_ADDR_W || DATA_W % meb_pkg::BYTE_W != 0 || DATA_W > 128) begin
      $error("meb_bridge: unsupported width");
    end
  end

  meb_pkg::meb_state_type state_ff;
  meb_pkg::meb_state_type nxt_state;

  logic [ADDR_W-1:0] extAddress_ff;
  logic [DATA_W-1:0] wrPayload_ff;
  logic [LANES-1:0]  laneSelect_ff;
  logic              isRead_ff;
  logic              transferValid_ff;
  logic [DATA_W-1:0] upRdData_ff;
  logic              upWaitRequest_ff;
  logic              upTimedOut_ff;
  logic              upIrq_ff;
  logic [CNT_W-1:0]  waitCnt_ff;

  logic              take;
  logic              inRange;
  logic              expired;
  logic [ADDR_W-1:0] alignMask;

  assign take    = upSelect && (upRead || upWrite);
  assign inRange = 64'(upAddress) < LIMIT;
  assign expired = (waitCnt_ff == CNT_LAST) && !doneStrobe;

  // Low address bits cleared so the bus address matches the data size
  generate
    if (LANES > 1) begin : g_align
      assign alignMask = {{(ADDR_W-LOW_BITS){1'b1}}, {LOW_BITS{1'b0}}};
    end else begin : g_noalign
      assign alignMask = '1;
    end
  endgenerate

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      meb_pkg::ST_IDLE: begin
        if (take) begin
          nxt_state = inRange ? meb_pkg::ST_SETUP : meb_pkg::ST_DONE;
        end
      end
      meb_pkg::ST_SETUP: begin
        nxt_state = meb_pkg::ST_WAIT;
      end
      meb_pkg::ST_WAIT: begin
        if (doneStrobe) begin
          nxt_state = isRead_ff ? meb_pkg::ST_CAPTURE : meb_pkg::ST_DONE;
        end else if (expired) begin
          nxt_state = meb_pkg::ST_DONE;
        end
      end
      meb_pkg::ST_CAPTURE: begin
        nxt_state = meb_pkg::ST_DONE;
      end
      meb_pkg::ST_DONE: begin
        nxt_state = meb_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = meb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= meb_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Request fields latched once and held for the whole transfer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extAddress_ff <= '0;
      wrPayload_ff  <= '0;
      laneSelect_ff <= '0;
      isRead_ff     <= meb_pkg::DIR_WRITE;
    end else if (state_ff == meb_pkg::ST_IDLE && take && inRange) begin
      extAddress_ff <= upAddress & alignMask;
      wrPayload_ff  <= upWrData;
      laneSelect_ff <= upLanes;
      isRead_ff     <= upRead ? meb_pkg::DIR_READ : meb_pkg::DIR_WRITE;
    end
  end

  // Valid rises only after the fields have stood a cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      transferValid_ff <= 1'b0;
    end else if (state_ff == meb_pkg::ST_SETUP) begin
      transferValid_ff <= 1'b1;
    end else if (state_ff == meb_pkg::ST_WAIT && (doneStrobe || expired)) begin
      transferValid_ff <= 1'b0;
    end
  end

  // Counts cycles with valid high; cleared in every state other than WAIT
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt_ff <= '0;
    end else if (state_ff == meb_pkg::ST_WAIT) begin
      waitCnt_ff <= waitCnt_ff + CNT_W'(1);
    end else begin
      waitCnt_ff <= '0;
    end
  end

  // Read data captured on the completion strobe; a lone strobe pulse is assumed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upRdData_ff <= '0;
    end else if (state_ff == meb_pkg::ST_IDLE && take) begin
      upRdData_ff <= '0;
    end else if (state_ff == meb_pkg::ST_WAIT && doneStrobe && isRead_ff) begin
      upRdData_ff <= rdPayload;
    end
  end

  // Wait request held high except for the single completing cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upWaitRequest_ff <= 1'b1;
    end else begin
      upWaitRequest_ff <= (nxt_state != meb_pkg::ST_DONE);
    end
  end

  // Flags an access that ended by time-out; read data is then zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upTimedOut_ff <= 1'b0;
    end else if (state_ff == meb_pkg::ST_WAIT && expired) begin
      upTimedOut_ff <= 1'b1;
    end else if (state_ff == meb_pkg::ST_IDLE && take) begin
      upTimedOut_ff <= 1'b0;
    end
  end

  // Same clock as the peripheral, so one register and no synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upIrq_ff <= 1'b0;
    end else begin
      upIrq_ff <= periphIrq;
    end
  end

  assign extAddress    = extAddress_ff;
  assign wrPayload     = wrPayload_ff;
  assign laneSelect    = laneSelect_ff;
  assign isRead        = isRead_ff;
  assign transferValid = transferValid_ff;
  assign upRdData      = upRdData_ff;
  assign upWaitRequest = upWaitRequest_ff;
  assign upTimedOut    = upTimedOut_ff;
  assign upIrq         = upIrq_ff;

  // Checks
  logic [CNT_W:0] validRun_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      validRun_ff <= '0;
    end else if (transferValid_ff) begin
      validRun_ff <= validRun_ff + (CNT_W+1)'(1);
    end else begin
      validRun_ff <= '0;
    end
  end

  sequence s_start;
    state_ff == meb_pkg::ST_IDLE && take && inRange;
  endsequence

  sequence s_ack_wr;
    transferValid_ff && doneStrobe && !isRead_ff;
  endsequence

  sequence s_ack_rd;
    transferValid_ff && doneStrobe && isRead_ff;
  endsequence

  chk_addr_aligned: assert property (@(posedge clk) disable iff (!reset_n)
    transferValid_ff |-> (extAddress_ff & ~alignMask) == '0)
    else $error("external address not aligned");

  chk_fields_latched: assert property (@(posedge clk) disable iff (!reset_n)
    s_start |=> laneSelect_ff == $past(upLanes) && wrPayload_ff == $past(upWrData))
    else $error("lanes or write data not taken from request");

  chk_dir_code: assert property (@(posedge clk) disable iff (!reset_n)
    s_start |=> isRead_ff == $past(upRead))
    else $error("direction code wrong");

  chk_setup_first: assert property (@(posedge clk) disable iff (!reset_n)
    s_start |=> !transferValid_ff ##1 transferValid_ff && $stable(extAddress_ff))
    else $error("valid did not follow one setup cycle");

  chk_fields_stable: assert property (@(posedge clk) disable iff (!reset_n)
    transferValid_ff && $past(transferValid_ff) |->
      $stable(extAddress_ff) && $stable(laneSelect_ff) && $stable(isRead_ff))
    else $error("bus fields moved while valid");

  chk_valid_drop: assert property (@(posedge clk) disable iff (!reset_n)
    transferValid_ff && doneStrobe |=> !transferValid_ff)
    else $error("valid not dropped after completion");

  chk_write_latency: assert property (@(posedge clk) disable iff (!reset_n)
    s_ack_wr |=> !upWaitRequest_ff ##1 upWaitRequest_ff)
    else $error("write completion not one cycle later");

  chk_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
    s_ack_rd |=> upWaitRequest_ff ##1 (!upWaitRequest_ff && upRdData_ff == $past(rdPayload, 2)))
    else $error("read completion not two cycles later");

  chk_timeout_bound: assert property (@(posedge clk) disable iff (!reset_n)
    validRun_ff <= (CNT_W+1)'(TIMEOUT_CYCLES))
    else $error("valid held beyond time-out");

  chk_timeout_done: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == meb_pkg::ST_WAIT && expired |=> !transferValid_ff && !upWaitRequest_ff && upTimedOut_ff)
    else $error("time-out did not end the access");

  chk_range_skip: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == meb_pkg::ST_IDLE && take && !inRange |=> !upWaitRequest_ff && !transferValid_ff)
    else $error("out-of-range access reached the bus");

  chk_irq_follow: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 upIrq_ff == $past(periphIrq))
    else $error("interrupt not passed upstream");

endmodule : meb_bridge

`default_nettype wire

// ---- dv/meb_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Peripheral on the external bus: answers after ackDelay+1 valid cycles, never while mute
module meb_periph_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Bus from the bridge
  input  wire logic [15:0] extAddress,
  input  wire logic [31:0] wrPayload,
  input  wire logic [3:0]  laneSelect,
  input  wire logic        isRead,
  input  wire logic        transferValid,
  // Answer
  output logic      [31:0] rdPayload,
  output logic             doneStrobe,
  // Test controls
  input  wire logic [3:0]  ackDelay,
  input  wire logic        mute
);
  logic [31:0] memFf [16];
  logic [3:0]  waitCntFf;
  logic        ackedFf;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCntFf  <= 4'h0;
      ackedFf    <= 1'b0;
      doneStrobe <= 1'b0;
      rdPayload  <= 32'h0;
    end else begin
      doneStrobe <= 1'b0;
      // Data is not held outside the answer cycle, so a stale capture shows up
      rdPayload  <= ~rdPayload;
      if (!transferValid) begin
        waitCntFf <= 4'h0;
        ackedFf   <= 1'b0;
      end else if (!ackedFf && !mute && waitCntFf == ackDelay) begin
        ackedFf    <= 1'b1;
        doneStrobe <= 1'b1;
        if (isRead) begin
          rdPayload <= memFf[extAddress[5:2]];
        end else begin
          for (int i = 0; i < 4; i++) begin
            if (laneSelect[i]) memFf[extAddress[5:2]][8*i+:8] <= wrPayload[8*i+:8];
          end
        end
      end else if (!ackedFf) begin
        waitCntFf <= waitCntFf + 4'h1;
      end
    end
  end
endmodule : meb_periph_model

`default_nettype wire

// ---- dv/meb_bridge_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module meb_bridge_tb;
  logic clk = 0, reset_n = 0, upSelect = 0, upRead = 0, upWrite = 0, periphIrq = 0, mute = 0;
  logic [15:0] upAddress = 16'h0, extAddress;
  logic [3:0]  upLanes = 4'h0, laneSelect, ackDelay = 4'h0;
  logic [31:0] upWrData = 32'h0, upRdData, wrPayload, rdPayload, rdv;
  logic        upWaitRequest, upTimedOut, upIrq, isRead, transferValid, doneStrobe, vPrev = 0, seenDir;
  logic [15:0] seenAddr;
  int          error_cnt = 0, tests_run = 0, rises = 0, n, m;

  meb_bridge #(.DATA_W(32), .ADDR_W(16), .RANGE_COUNT(64'h40), .RANGE_UNIT(meb_pkg::UNIT_BYTES),
    .TIMEOUT_CYCLES(4)) u_dut (.clk(clk), .reset_n(reset_n), .upSelect(upSelect), .upRead(upRead),
    .upWrite(upWrite), .upAddress(upAddress), .upLanes(upLanes), .upWrData(upWrData),
    .upRdData(upRdData), .upWaitRequest(upWaitRequest), .upTimedOut(upTimedOut), .upIrq(upIrq),
    .extAddress(extAddress), .wrPayload(wrPayload), .laneSelect(laneSelect), .isRead(isRead),
    .transferValid(transferValid), .rdPayload(rdPayload), .doneStrobe(doneStrobe), .periphIrq(periphIrq));

  meb_periph_model u_periph (.clk(clk), .reset_n(reset_n), .extAddress(extAddress),
    .wrPayload(wrPayload), .laneSelect(laneSelect), .isRead(isRead), .transferValid(transferValid),
    .rdPayload(rdPayload), .doneStrobe(doneStrobe), .ackDelay(ackDelay), .mute(mute));

  initial begin
    forever #50 clk = ~clk;
  end

  // Mid-cycle monitor of the external bus
  always @(negedge clk) begin
    if (transferValid && !vPrev) rises++;
    if (transferValid) begin
      seenDir  = isRead;
      seenAddr = extAddress;
    end
    vPrev = transferValid;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One upstream access; n counts mid-cycle looks until the stall drops
  task automatic access(input logic rd, input logic [15:0] a, input logic [3:0] ln, input logic [31:0] wd);
    @(posedge clk);
    #5;
    upSelect  = 1;
    upRead    = rd;
    upWrite   = !rd;
    upAddress = a;
    upLanes   = ln;
    upWrData  = wd;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (upWaitRequest !== 1'b0 && n < 40);
    rdv = upRdData;
    @(posedge clk);
    #5;
    upSelect = 0;
    upRead   = 0;
    upWrite  = 0;
  endtask : access

  task automatic t_reset;
    check("wait in reset", 32'h1, {31'h0, upWaitRequest});
    check("valid in reset", 32'h0, {31'h0, transferValid});
  endtask : t_reset

  task automatic t_write_read;
    access(0, 16'h0008, 4'hf, 32'h1122_3344);
    check("write latency", 32'h5, 32'(n));
    check("write dir", 32'h0, {31'h0, seenDir});
    access(0, 16'h000a, 4'h2, 32'haabb_ccdd);
    check("aligned addr", 32'h8, {16'h0, seenAddr});
    access(1, 16'h0008, 4'hf, 32'h0);
    check("read latency", 32'h6, 32'(n));
    check("read dir", 32'h1, {31'h0, seenDir});
    check("lane merge", 32'h1122_cc44, rdv);
  endtask : t_write_read

  // Answer lands in the last valid cycle the time-out allows
  task automatic t_slow;
    ackDelay = 4'h2;
    access(1, 16'h0008, 4'hf, 32'h0);
    check("slow read latency", 32'h8, 32'(n));
    check("slow read data", 32'h1122_cc44, rdv);
    ackDelay = 4'h0;
  endtask : t_slow

  task automatic t_out_of_range;
    m = rises;
    access(1, 16'h0040, 4'hf, 32'h0);
    check("range latency", 32'h2, 32'(n));
    check("range data", 32'h0, rdv);
    check("range bus idle", 32'(m), 32'(rises));
  endtask : t_out_of_range

  task automatic t_timeout;
    mute = 1;
    access(1, 16'h0004, 4'hf, 32'h0);
    check("timeout latency", 32'h7, 32'(n));
    check("timeout data", 32'h0, rdv);
    check("timeout flag", 32'h1, {31'h0, upTimedOut});
    check("timeout valid", 32'h0, {31'h0, transferValid});
    mute = 0;
    access(0, 16'h0004, 4'hf, 32'h5);
    check("flag cleared", 32'h0, {31'h0, upTimedOut});
  endtask : t_timeout

  task automatic t_irq;
    periphIrq = 1;
    repeat (2) @(posedge clk);
    #5;
    check("irq high", 32'h1, {31'h0, upIrq});
    periphIrq = 0;
    repeat (2) @(posedge clk);
    #5;
    check("irq low", 32'h0, {31'h0, upIrq});
  endtask : t_irq

  // Reset in mid-transfer must drop valid at once and leave nothing pending
  task automatic t_mid_reset;
    mute = 1;
    @(posedge clk);
    #5;
    upSelect  = 1;
    upRead    = 1;
    upAddress = 16'h0004;
    upLanes   = 4'hf;
    repeat (3) @(posedge clk);
    #5;
    check("valid before reset", 32'h1, {31'h0, transferValid});
    reset_n  = 0;
    upSelect = 0;
    upRead   = 0;
    #5;
    check("valid in mid reset", 32'h0, {31'h0, transferValid});
    check("wait in mid reset", 32'h1, {31'h0, upWaitRequest});
    @(posedge clk);
    #5;
    reset_n = 1;
    mute    = 0;
    access(1, 16'h0008, 4'hf, 32'h0);
    check("read after reset", 32'h1122_cc44, rdv);
    check("latency after reset", 32'h6, 32'(n));
  endtask : t_mid_reset

  task automatic summarize;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // Whole run is under a hundred cycles; this is ample margin
  initial begin
    #2_000_000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk);
    t_reset();
    #5;
    reset_n = 1;
    t_write_read();
    t_slow();
    t_out_of_range();
    t_timeout();
    t_irq();
    t_mid_reset();
    summarize();
  end
endmodule : meb_bridge_tb

`default_nettype wire
